// [inc/accel_cfg.svh]
// register map constants and field layout for the accelerometer register bank
//
// What the document requires
// RULE1: queued modes serve axis outputs from buffer
// RULE2: each pop loads oldest x y z set
// RULE3: single-byte read drops rest of sample
// RULE4: host reads all needed axes in one burst
// RULE5: host waits 5 us after data reads
// RULE6: pop on address 0x37 to 0x38 or deselect
// RULE7: at 1.6 MHz or less no wait needed
// RULE8: above 1.6 MHz host deselects between reads
// RULE9: at 5 MHz extra delay at most 3.4 us
// RULE10: two-wire bus needs no extra delay
// RULE11: self-check bit shifts all three axis outputs
// RULE12: self-check needs normal power and fit rate
// RULE13: host never touches addresses 0x01 to 0x1C
// RULE14: rate register resets 0x0A, others zero
// RULE15: interrupt source resets with bit 1 set
// RULE16: buffer mode in bits 7:6, bypass empty
// RULE17: overrun clears when buffer is read out
// RULE18: watermark clears below programmed sample count
// RULE19: burst reads advance address each byte
`ifndef ACCEL_CFG_SVH
`define ACCEL_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADDR_PART_ID 6'h00
`define ADDR_TAP_THRESH 6'h1D
`define ADDR_X_TRIM 6'h1E
`define ADDR_Y_TRIM 6'h1F
`define ADDR_Z_TRIM 6'h20
`define ADDR_TAP_MAX_LEN 6'h21
`define ADDR_TAP_LATENCY 6'h22
`define ADDR_DTAP_SLOT 6'h23
`define ADDR_ACT_THRESH 6'h24
`define ADDR_INACT_THRESH 6'h25
`define ADDR_INACT_TIME 6'h26
`define ADDR_MOTION_AXIS 6'h27
`define ADDR_FF_THRESH 6'h28
`define ADDR_FF_TIME 6'h29
`define ADDR_TAP_AXIS 6'h2A
`define ADDR_MOTION_SRC 6'h2B
`define ADDR_RATE 6'h2C
`define ADDR_POWER 6'h2D
`define ADDR_IRQ_EN 6'h2E
`define ADDR_IRQ_ROUTE 6'h2F
`define ADDR_IRQ_SRC 6'h30
`define ADDR_FMT 6'h31
`define ADDR_X_LOW 6'h32
`define ADDR_X_HIGH 6'h33
`define ADDR_Y_LOW 6'h34
`define ADDR_Y_HIGH 6'h35
`define ADDR_Z_LOW 6'h36
`define ADDR_Z_HIGH 6'h37
`define ADDR_QUEUE_CTL 6'h38
`define ADDR_QUEUE_STAT 6'h39

// ----------------------------------------
// reset values and fields
// ----------------------------------------
`define CFG_RST 8'h00
`define RATE_RST 8'h0A
`define IRQ_SRC_RST 8'h02
`define QCTL_MODE_HI 7
`define QCTL_MODE_LO 6
`define QCTL_SAMPLES_HI 4
`define FMT_SELF_TEST_BIT 7
`define CMD_READ_BIT 7
`define CMD_MULTI_BIT 6
`define IRQ_READY_BIT 7
`define IRQ_WMARK_BIT 1
`define IRQ_OVERRUN_BIT 0
`define SELF_TEST_SHIFT 16'h0040

// ----------------------------------------
// timing
// ----------------------------------------
`define REF_CLK_NS 100
`define POP_SETTLE_NS 5000
`define POP_SETTLE_CYC ((`POP_SETTLE_NS + `REF_CLK_NS - 1) / `REF_CLK_NS)

`endif

// [inc/accel_pkg.sv]
// types shared by the accelerometer register bank
`default_nettype none
package accel_pkg;
  typedef enum logic [1:0] {
    QM_BYPASS = 2'h0,
    QM_FIFO = 2'h1,
    QM_STREAM = 2'h2,
    QM_TRIGGER = 2'h3
  } queue_mode_t;

  typedef enum logic [1:0] {
    SP_IDLE,
    SP_CMD,
    SP_DATA
  } spi_state_t;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } sample_t;
endpackage
`default_nettype wire

// [hw/accel_regmap.sv]
// accelerometer register bank with serial slave and sample queue readout
`default_nettype none
`include "accel_cfg.svh"

// ----------------------------------------
// sample queue
// ----------------------------------------
module sample_queue #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 32
) (
  // clock, reset and flush
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_flush,
  // fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  // drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data,
  output logic [$clog2(DEPTH):0] o_count
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("sample_queue depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign o_valid = count_r != '0;
  // a pop in the same cycle frees a slot, so a full queue can still take a word
  assign o_ready = (count_r != (AW+1)'(DEPTH)) || i_ready;
  assign push = i_valid && o_ready && !i_flush;
  assign pop = o_valid && i_ready && !i_flush;
  assign o_data = mem[rd_ptr_r];
  assign o_count = count_r;

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= i_data;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else if (i_flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ----------------------------------------
// register bank top
// ----------------------------------------
module accel_regmap #(
  parameter int QUEUE_DEPTH = 32,
  // arbitrary identification value
  parameter logic [7:0] PART_ID = 8'h5A
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // serial link pins
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_sdi,
  output logic o_sdo,
  output logic o_sdo_oe,
  // measurement front end
  input wire logic i_sample_valid,
  input wire accel_pkg::sample_t i_sample,
  output logic o_self_test,
  output logic [7:0] o_rate_power_control
);
  localparam int CW = $clog2(QUEUE_DEPTH) + 1;
  localparam int POP_CYC = `POP_SETTLE_CYC;
  if (QUEUE_DEPTH < 2 || QUEUE_DEPTH > 32) begin : g_bad_depth
    $error("queue depth must lie between 2 and 32");
  end
  // deselect to pop takes four cycles through the synchroniser
  if (POP_CYC <= 3) begin : g_bad_clock
    $error("reference clock too slow to finish a pop within the settle time");
  end

  function automatic logic is_data_addr(input logic [5:0] a);
    is_data_addr = (a >= `ADDR_X_LOW) && (a <= `ADDR_Z_HIGH);
  endfunction

  function automatic logic is_cfg_addr(input logic [5:0] a);
    is_cfg_addr = (a >= `ADDR_TAP_THRESH) && (a <= `ADDR_FMT);
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic cs_n_s1, cs_n_s2, cs_n_d;
  logic sclk_s1, sclk_s2, sclk_d;
  logic sdi_s1, sdi_s2;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cs_n_s1 <= 1'b1;
      cs_n_s2 <= 1'b1;
      cs_n_d <= 1'b1;
      sclk_s1 <= 1'b1;
      sclk_s2 <= 1'b1;
      sclk_d <= 1'b1;
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
    end else begin
      cs_n_s1 <= i_cs_n;
      cs_n_s2 <= cs_n_s1;
      cs_n_d <= cs_n_s2;
      sclk_s1 <= i_sclk;
      sclk_s2 <= sclk_s1;
      sclk_d <= sclk_s2;
      sdi_s1 <= i_sdi;
      sdi_s2 <= sdi_s1;
    end
  end

  logic sclk_rise, sclk_fall, deselect;
  assign sclk_rise = sclk_s2 && !sclk_d && !cs_n_s2;
  assign sclk_fall = !sclk_s2 && sclk_d && !cs_n_s2;
  assign deselect = cs_n_s2 && !cs_n_d;

  // ----------------------------------------
  // serial frame decoder
  // ----------------------------------------
  accel_pkg::spi_state_t state_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] rx_r, tx_r;
  logic [5:0] addr_r;
  logic rd_r, multi_r, load_tx_r;
  logic [7:0] rx_byte, rd_byte;
  logic byte_done, wr_en;

  assign rx_byte = {rx_r[6:0], sdi_s2};
  assign byte_done = sclk_rise && (bit_cnt_r == 3'h7);
  assign wr_en = (state_r == accel_pkg::SP_DATA) && !rd_r && byte_done;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= accel_pkg::SP_IDLE;
      bit_cnt_r <= 3'h0;
      rx_r <= 8'h00;
      addr_r <= 6'h00;
      rd_r <= 1'b0;
      multi_r <= 1'b0;
    end else if (cs_n_s2) begin
      state_r <= accel_pkg::SP_IDLE;
      bit_cnt_r <= 3'h0;
    end else begin
      if (sclk_rise) begin
        rx_r <= rx_byte;
        bit_cnt_r <= bit_cnt_r + 3'h1;
      end
      unique case (state_r)
        accel_pkg::SP_IDLE: begin
          state_r <= accel_pkg::SP_CMD;
        end
        accel_pkg::SP_CMD: begin
          if (byte_done) begin
            rd_r <= rx_byte[`CMD_READ_BIT];
            multi_r <= rx_byte[`CMD_MULTI_BIT];
            addr_r <= rx_byte[5:0];
            state_r <= accel_pkg::SP_DATA;
          end
        end
        accel_pkg::SP_DATA: begin
          if (byte_done && multi_r) begin
            addr_r <= addr_r + 6'h01; // [RULE19]
          end
        end
      endcase
    end
  end

  // shift out on the falling edge so the bit is stable at the next rise
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      load_tx_r <= 1'b0;
      tx_r <= 8'h00;
      o_sdo <= 1'b0;
      o_sdo_oe <= 1'b0;
    end else begin
      load_tx_r <= byte_done;
      o_sdo_oe <= !cs_n_s2 && (state_r == accel_pkg::SP_DATA) && rd_r;
      if (cs_n_s2) begin
        o_sdo <= 1'b0;
      end else if (load_tx_r) begin
        tx_r <= rd_byte;
      end else if (sclk_fall && state_r == accel_pkg::SP_DATA && rd_r) begin
        o_sdo <= tx_r[7];
        tx_r <= {tx_r[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic [7:0] cfg_r [`ADDR_TAP_THRESH:`ADDR_FMT];
  logic [7:0] queue_ctl_r;
  accel_pkg::queue_mode_t mode;
  logic bypass;
  logic [4:0] samples;

  assign mode = accel_pkg::queue_mode_t'(queue_ctl_r[`QCTL_MODE_HI:`QCTL_MODE_LO]); // [RULE16]
  assign bypass = mode == accel_pkg::QM_BYPASS;
  assign samples = queue_ctl_r[`QCTL_SAMPLES_HI:0];

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = `ADDR_TAP_THRESH; i <= `ADDR_FMT; i++) begin
        cfg_r[i] <= `CFG_RST; // [RULE14]
      end
      cfg_r[`ADDR_RATE] <= `RATE_RST; // [RULE14]
      queue_ctl_r <= `CFG_RST;
    end else if (wr_en) begin
      // read-only slots inside the range stay at their reset value
      if (is_cfg_addr(addr_r) && addr_r != `ADDR_MOTION_SRC && addr_r != `ADDR_IRQ_SRC) begin
        cfg_r[addr_r] <= rx_byte;
      end
      if (addr_r == `ADDR_QUEUE_CTL) begin
        queue_ctl_r <= rx_byte;
      end
    end
  end

  assign o_self_test = cfg_r[`ADDR_FMT][`FMT_SELF_TEST_BIT];
  assign o_rate_power_control = cfg_r[`ADDR_RATE];

  // ----------------------------------------
  // sample path and queue
  // ----------------------------------------
  accel_pkg::sample_t stim, data_r, q_data;
  logic q_in_ready, q_valid, q_out_ready, head_r, unread_r, overrun_r;
  logic [CW-1:0] q_count;
  logic q_full, load_head, drop_oldest, data_touch_r, read_end, overrun_set;
  logic [5:0] entries;
  logic watermark;
  logic [7:0] irq_src;

  always_comb begin
    stim = i_sample;
    if (o_self_test) begin
      stim.x = i_sample.x + `SELF_TEST_SHIFT; // [RULE11]
      stim.y = i_sample.y + `SELF_TEST_SHIFT; // [RULE11]
      stim.z = i_sample.z + `SELF_TEST_SHIFT; // [RULE11]
    end
  end

  assign q_full = q_count == CW'(QUEUE_DEPTH);
  assign load_head = !bypass && !head_r && q_valid;
  // trigger mode keeps the newest samples like stream mode; no trigger source here
  assign drop_oldest = (mode == accel_pkg::QM_STREAM || mode == accel_pkg::QM_TRIGGER)
    && i_sample_valid && q_full && !load_head;
  assign q_out_ready = load_head || drop_oldest;

  sample_queue #(
    .WIDTH($bits(accel_pkg::sample_t)),
    .DEPTH(QUEUE_DEPTH)
  ) u_queue (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_flush(bypass), // [RULE16]
    .i_valid(i_sample_valid && !bypass),
    .o_ready(q_in_ready),
    .i_data(stim),
    .o_valid(q_valid),
    .i_ready(q_out_ready),
    .o_data(q_data),
    .o_count(q_count)
  );

  // a data read ends on deselect or on the burst stepping past the last axis byte
  assign read_end = (deselect && data_touch_r) ||
    ((state_r == accel_pkg::SP_DATA) && rd_r && byte_done && multi_r &&
    addr_r == `ADDR_Z_HIGH); // [RULE6] [RULE3]

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      data_touch_r <= 1'b0;
    end else if (read_end) begin
      data_touch_r <= 1'b0;
    end else if (load_tx_r && rd_r && is_data_addr(addr_r)) begin
      data_touch_r <= 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      data_r <= '0;
      head_r <= 1'b0;
    end else if (bypass) begin
      head_r <= 1'b0;
      if (i_sample_valid) begin
        data_r <= stim;
      end
    end else if (read_end) begin
      head_r <= 1'b0; // [RULE6]
    end else if (load_head) begin
      data_r <= q_data; // [RULE1] [RULE2]
      head_r <= 1'b1;
    end
  end

  assign overrun_set = i_sample_valid &&
    (bypass ? unread_r : (!q_in_ready || drop_oldest));

  // sticky flags: a new event in the clearing cycle wins
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      unread_r <= 1'b0;
      overrun_r <= 1'b0;
    end else begin
      if (bypass && i_sample_valid) begin
        unread_r <= 1'b1;
      end else if (read_end || !bypass) begin
        unread_r <= 1'b0;
      end
      if (overrun_set) begin
        overrun_r <= 1'b1;
      end else if (read_end) begin
        overrun_r <= 1'b0; // [RULE17]
      end
    end
  end

  assign entries = 6'(q_count) + 6'(head_r);
  assign watermark = entries >= 6'(samples); // [RULE18]
  always_comb begin
    irq_src = 8'h00;
    irq_src[`IRQ_READY_BIT] = bypass ? unread_r : head_r;
    irq_src[`IRQ_WMARK_BIT] = watermark; // [RULE15]
    irq_src[`IRQ_OVERRUN_BIT] = overrun_r;
  end

  // ----------------------------------------
  // read multiplexer
  // ----------------------------------------
  always_comb begin
    rd_byte = 8'h00;
    case (addr_r)
      `ADDR_PART_ID: rd_byte = PART_ID;
      `ADDR_MOTION_SRC: rd_byte = 8'h00;
      `ADDR_IRQ_SRC: rd_byte = irq_src;
      `ADDR_X_LOW: rd_byte = data_r.x[7:0];
      `ADDR_X_HIGH: rd_byte = data_r.x[15:8];
      `ADDR_Y_LOW: rd_byte = data_r.y[7:0];
      `ADDR_Y_HIGH: rd_byte = data_r.y[15:8];
      `ADDR_Z_LOW: rd_byte = data_r.z[7:0];
      `ADDR_Z_HIGH: rd_byte = data_r.z[15:8];
      `ADDR_QUEUE_CTL: rd_byte = queue_ctl_r;
      `ADDR_QUEUE_STAT: rd_byte = {2'h0, entries};
      default: begin
        if (is_cfg_addr(addr_r)) begin
          rd_byte = cfg_r[addr_r];
        end
      end
    endcase
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  logic seen_r;
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      seen_r <= 1'b0;
    end else begin
      seen_r <= 1'b1;
    end
  end

  property p_reset_values;
    !seen_r |-> cfg_r[`ADDR_RATE] == `RATE_RST && cfg_r[`ADDR_FMT] == `CFG_RST
      && queue_ctl_r == `CFG_RST;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("bad reset values"); // [RULE14]

  property p_irq_reset;
    !seen_r |-> irq_src == `IRQ_SRC_RST;
  endproperty
  a_irq_reset: assert property (p_irq_reset) else $error("bad irq source reset"); // [RULE15]

  property p_bypass_empty;
    bypass ##1 bypass |-> q_count == '0 && !head_r;
  endproperty
  a_bypass_empty: assert property (p_bypass_empty) else $error("queue not empty"); // [RULE16]

  property p_head_load;
    load_head && !read_end |=> head_r && data_r == $past(q_data);
  endproperty
  a_head_load: assert property (p_head_load) else $error("head not loaded"); // [RULE2]

  // the held sample goes at once, and the next queued one is in place a cycle later
  property p_deselect_pop;
    !bypass && data_touch_r && $rose(cs_n_s2) |=> !head_r ##1 head_r == $past(q_valid);
  endproperty
  a_deselect_pop: assert property (p_deselect_pop) else $error("no pop on deselect"); // [RULE3]

  property p_burst_end;
    state_r == accel_pkg::SP_DATA && rd_r && multi_r && byte_done && addr_r == `ADDR_Z_HIGH
      && !bypass |=> !head_r ##1 addr_r == `ADDR_QUEUE_CTL;
  endproperty
  a_burst_end: assert property (p_burst_end) else $error("no pop past last axis"); // [RULE6]

  property p_overrun_clear;
    read_end && !overrun_set |=> !overrun_r;
  endproperty
  a_overrun_clear: assert property (p_overrun_clear) else $error("overrun kept"); // [RULE17]

  property p_watermark;
    entries < 6'(samples) |-> !rd_byte[`IRQ_WMARK_BIT] || addr_r != `ADDR_IRQ_SRC;
  endproperty
  a_watermark: assert property (p_watermark) else $error("watermark stuck"); // [RULE18]

  property p_self_test;
    bypass && i_sample_valid && o_self_test |=>
      data_r.x == $past(i_sample.x) + `SELF_TEST_SHIFT;
  endproperty
  a_self_test: assert property (p_self_test) else $error("no self test shift"); // [RULE11]

  property p_auto_inc;
    state_r == accel_pkg::SP_DATA && byte_done && multi_r && !cs_n_s2 |=>
      addr_r == 6'($past(addr_r) + 6'h01);
  endproperty
  a_auto_inc: assert property (p_auto_inc) else $error("address not advanced"); // [RULE19]

  c_burst_pop: cover property (read_end && !deselect);
  c_single_byte: cover property (deselect && data_touch_r);
  c_stream_drop: cover property (drop_oldest);
  c_overrun: cover property (overrun_set && !bypass);
endmodule
`default_nettype wire

// [bench/spi_host_model.sv]
// host-side serial controller model that drives the register bank link
`default_nettype none

module spi_host_model (
  // clock
  input wire logic i_ref_clk,
  // serial link
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_sdi,
  input wire logic i_miso,
  // read results
  output logic o_rd_valid,
  output logic [7:0] o_rd_byte
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b1;
    o_sdi = 1'b0;
    o_rd_valid = 1'b0;
    o_rd_byte = 8'h00;
  end

  // ----------------------------------------
  // one frame
  // ----------------------------------------
  // sclk idles high and stands still between frames; 800 ns period, msb first
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, input int nb);
    logic [7:0] sh;
    logic [7:0] rd;
    @(posedge i_ref_clk);
    o_cs_n <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    for (int b = 0; b <= nb; b++) begin
      sh = (b == 0) ? cmd : wd;
      for (int i = 7; i >= 0; i--) begin
        o_sclk <= 1'b0;
        o_sdi <= sh[i];
        repeat (4) @(posedge i_ref_clk);
        o_sclk <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        rd[i] = i_miso;
        repeat (2) @(posedge i_ref_clk);
      end
      if (b > 0 && cmd[7]) begin
        o_rd_byte <= rd;
        o_rd_valid <= 1'b1;
        @(posedge i_ref_clk);
        o_rd_valid <= 1'b0;
      end
    end
    repeat (4) @(posedge i_ref_clk);
    o_cs_n <= 1'b1;
    // released data line must not look like the last bit
    o_sdi <= ~o_sdi;
    // deselect gap of 5 us lets a pop settle before the next frame
    repeat (50) @(posedge i_ref_clk);
  endtask
endmodule
`default_nettype wire

// [bench/tb.sv]
// self-checking testbench for the accelerometer register bank
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // arbitrary identification value
  localparam logic [7:0] ID_VAL = 8'h3C;
  logic clk, rst_n, cs_n, sclk, sdi, sdo, sdo_oe, smp_valid, self_test, tog, rd_valid;
  logic st_on;
  logic miso;
  logic [7:0] rate, rd_byte, v;
  accel_pkg::sample_t smp, e;
  logic [7:0] exp_q[$];
  string name_q[$];
  accel_pkg::sample_t model_q[$];
  int n_mismatch = 0;
  int check_count = 0;

  // undriven line shows a changing pattern, never a stale bit
  assign miso = sdo_oe ? sdo : tog;

  accel_regmap #(.QUEUE_DEPTH(32), .PART_ID(ID_VAL)) dut (
    .i_ref_clk(clk), .i_reset_n(rst_n), .i_cs_n(cs_n), .i_sclk(sclk), .i_sdi(sdi),
    .o_sdo(sdo), .o_sdo_oe(sdo_oe), .i_sample_valid(smp_valid), .i_sample(smp),
    .o_self_test(self_test), .o_rate_power_control(rate));

  spi_host_model host (
    .i_ref_clk(clk), .o_cs_n(cs_n), .o_sclk(sclk), .o_sdi(sdi), .i_miso(miso),
    .o_rd_valid(rd_valid), .o_rd_byte(rd_byte));

  // ----------------------------------------
  // checking
  // ----------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
    check_count++;
    if (seen !== want) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    tog <= ~tog;
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("[FAIL] read byte expected none seen %h", rd_byte);
      end else begin
        check(name_q.pop_front(), rd_byte, exp_q.pop_front());
      end
    end
  end

  // ----------------------------------------
  // stimulus tasks
  // ----------------------------------------
  task automatic note(input logic [7:0] want, input string nm);
    exp_q.push_back(want);
    name_q.push_back(nm);
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] want, input string nm);
    note(want, $sformatf("%s at %h", nm, a));
    host.xfer({2'b10, a}, 8'h00, 1);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] val);
    host.xfer({2'b00, a}, val, 1);
  endtask

  // new front-end sample; the model keeps it only while below cap
  task automatic put(input int cap);
    accel_pkg::sample_t s;
    s = {16'($urandom), 16'($urandom), 16'($urandom)};
    @(posedge clk);
    smp <= s;
    smp_valid <= 1'b1;
    @(posedge clk);
    smp_valid <= 1'b0;
    if (st_on) s = {s.x + 16'h0040, s.y + 16'h0040, s.z + 16'h0040};
    if (model_q.size() < cap) model_q.push_back(s);
  endtask

  // whole sample in one burst, low byte first per axis
  task automatic burst();
    logic [15:0] w;
    e = model_q.pop_front();
    for (int k = 0; k < 3; k++) begin
      w = e[47-16*k -: 16];
      note(w[7:0], "axis low");
      note(w[15:8], "axis high");
    end
    host.xfer(8'hF2, 8'h00, 6);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    $display("[FAIL] run length expected finish seen timeout");
    conclude();
  end

  initial begin
    rst_n = 1'b0;
    smp_valid = 1'b0;
    smp = '0;
    tog = 1'b0;
    st_on = 1'b0;
    void'($urandom(32'h1CA589B7));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check("rate pins", rate, 8'h0A);
    check("self test pin", {7'h00, self_test}, 8'h00);
    for (int a = 'h1D; a <= 'h39; a++) begin
      rd(6'(a), (a == 'h2C) ? 8'h0A : (a == 'h30) ? 8'h02 : 8'h00, "reset");
    end
    rd(6'h00, ID_VAL, "part id");
    // only the unmapped top is probed, reserved low addresses stay untouched
    rd(6'h3F, 8'h00, "unmapped");
    $display("test reset values done");

    for (int a = 'h1D; a <= 'h2F; a++) begin
      v = 8'($urandom);
      wr(6'(a), v);
      rd(6'(a), (a == 'h2B) ? 8'h00 : v, "read back");
    end
    wr(6'h00, 8'hFF);
    rd(6'h00, ID_VAL, "part id write");
    wr(6'h30, 8'hFF);
    rd(6'h30, 8'h02, "source write");
    wr(6'h3F, 8'hFF);
    rd(6'h3F, 8'h00, "unmapped write");
    wr(6'h2C, 8'h0D);
    @(negedge clk);
    check("rate pins", rate, 8'h0D);
    $display("test register access done");

    put(1);
    burst();
    rd(6'h39, 8'h00, "bypass entries");
    wr(6'h31, 8'h80);
    @(negedge clk);
    check("self test pin", {7'h00, self_test}, 8'h01);
    st_on = 1'b1;
    put(1);
    burst();
    wr(6'h31, 8'h00);
    st_on = 1'b0;
    $display("test bypass and self test done");

    for (int m = 1; m <= 3; m++) begin
      wr(6'h38, {2'(m), 6'h02});
      repeat (3) put(40);
      rd(6'h39, 8'h03, "entries");
      repeat (3) burst();
      wr(6'h38, 8'h00);
    end
    wr(6'h38, 8'h44);
    repeat (2) put(40);
    wr(6'h38, 8'h00);
    model_q.delete();
    rd(6'h39, 8'h00, "flushed entries");
    wr(6'h38, 8'h84);
    repeat (35) put(40);
    // stream keeps the held head plus the newest 32, so the two oldest queued go
    model_q.delete(1);
    model_q.delete(1);
    rd(6'h30, 8'h83, "stream overrun");
    repeat (2) burst();
    wr(6'h38, 8'h00);
    model_q.delete();
    $display("test queue modes done");

    wr(6'h38, 8'h44);
    repeat (34) put(33);
    rd(6'h39, 8'h21, "full entries");
    rd(6'h30, 8'h83, "overrun source");
    burst();
    rd(6'h30, 8'h82, "source after read");
    e = model_q.pop_front();
    note(e.x[7:0], "single byte");
    host.xfer(8'hB2, 8'h00, 1);
    while (model_q.size() > 0) burst();
    rd(6'h39, 8'h00, "drained entries");
    rd(6'h30, 8'h00, "drained source");
    $display("test fill and drain done");

    repeat (20) @(posedge clk);
    if (exp_q.size() != 0) begin
      n_mismatch++;
      $display("[FAIL] pending reads expected 0 seen %0d", exp_q.size());
    end
    conclude();
  end
endmodule
`default_nettype wire
